// ===== dv/lpm_ctrl_asserts.sv
// concurrent checks on the low power mode controller ports
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// checker
module lpm_ctrl_asserts
   import lpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic avs_write,
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic core_mask,
   input wire logic core_clk_en,
   input wire logic system_clock_out_en,
   input wire logic crystal_clock_en,
   input wire logic pll_run,
   input wire logic pll_select,
   input wire logic tbm_access_ok,
   input wire lpm_mode_t sci_mode,
   input wire lpm_mode_t spi_mode,
   input wire lpm_mode_t tim_mode
);
   int off_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // core clock off time outside wait, saturating to stay small
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         off_cnt <= 0;
      end else if (core_clk_en) begin
         off_cnt <= 0;
      end else if (!tim_mode.in_wait && off_cnt < 9000) begin
         off_cnt <= off_cnt + 1;
      end
   end
   sequence wait_go;
      wait_exec && !stop_exec && core_clk_en && !tim_mode.in_wait;
   endsequence
   sequence stop_go;
      $rose(tim_mode.in_stop);
   endsequence
   AST_WAIT_ENTRY: assert property (wait_go |=> tim_mode.in_wait &&
      !core_mask && !core_clk_en) else $error("wait entry wrong");
   AST_STOP_ENTRY: assert property (stop_go |-> !core_mask &&
      !core_clk_en && !pll_run) else $error("stop entry wrong");
   AST_STOP_CAUSE: assert property (stop_go |->
      $past(stop_exec) || $past(avs_write)) else $error("stop no cause");
   AST_STOP_PLL: assert property (tim_mode.in_stop |->
      !pll_select && !pll_run) else $error("pll live in stop");
   AST_STOP_HELD: assert property (stop_go |-> !core_clk_en [*8])
      else $error("core clock early");
   AST_RECOVER_MIN: assert property ($rose(core_clk_en) &&
      !$past(tim_mode.in_wait) |-> off_cnt >= 32)
      else $error("recovery too short");
   AST_MODES_AGREE: assert property (sci_mode == tim_mode &&
      spi_mode == tim_mode && !(tim_mode.in_wait && tim_mode.in_stop))
      else $error("mode flags differ");
   AST_TBM_BLOCK: assert property (tim_mode.in_wait |->
      !tbm_access_ok) else $error("timebase open in wait");
   AST_WAIT_CLOCKS: assert property (tim_mode.in_wait |->
      crystal_clock_en && system_clock_out_en)
      else $error("clocks off in wait");
endmodule
bind lpm_ctrl lpm_ctrl_asserts u_lpm_ctrl_asserts (.clk(clk), .rst(rst),
   .avs_write(avs_write), .wait_exec(wait_exec), .stop_exec(stop_exec),
   .core_mask(core_mask), .core_clk_en(core_clk_en),
   .system_clock_out_en(system_clock_out_en),
   .crystal_clock_en(crystal_clock_en), .pll_run(pll_run),
   .pll_select(pll_select), .tbm_access_ok(tbm_access_ok),
   .sci_mode(sci_mode), .spi_mode(spi_mode), .tim_mode(tim_mode));
`default_nettype wire

// ===== dv/lpm_ctrl_tb.sv
// self-checking bench for the low power mode controller
`include "lpm_map.svh"
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench top
module lpm_ctrl_tb
   import lpm_pkg::*;
;
   logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
   logic wait_exec = 0, stop_exec = 0, core_mask_set = 0;
   logic lvi_low = 0, tbm_access = 0;
   logic [3:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, rd;
   logic avs_waitrequest, core_mask, core_clk_en, crystal_clock_en;
   logic system_clock_out_en, clockgen_interrupt_en, pll_run, pll_select;
   logic wd_reset, lvi_reset, sys_reset_req, tbm_access_ok, spi_abort;
   lpm_wake_t wake_src = '0;
   lpm_mode_t brk_mode, sci_mode, spi_mode, tim_mode, tbm_mode;
   int fails = 0, checks_done = 0, n;
   lpm_ctrl u_lpm_ctrl (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .wait_exec(wait_exec),
      .stop_exec(stop_exec), .core_mask_set(core_mask_set),
      .wake_src(wake_src), .lvi_low(lvi_low), .tbm_access(tbm_access),
      .core_mask(core_mask), .core_clk_en(core_clk_en),
      .crystal_clock_en(crystal_clock_en),
      .system_clock_out_en(system_clock_out_en),
      .clockgen_interrupt_en(clockgen_interrupt_en), .pll_run(pll_run),
      .pll_select(pll_select), .wd_reset(wd_reset), .lvi_reset(lvi_reset),
      .sys_reset_req(sys_reset_req), .tbm_access_ok(tbm_access_ok),
      .brk_mode(brk_mode), .sci_mode(sci_mode), .spi_mode(spi_mode),
      .tim_mode(tim_mode), .tbm_mode(tbm_mode), .spi_abort(spi_abort));
   // 40 MHz clock
   always #12.5 clk = ~clk;
   task close_out;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // avalon access; request held until waitrequest is seen low at an edge
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      rd = avs_readdata;
      avs_write <= 0;
      avs_read <= 0;
      if (k >= 20) begin
         fails++;
         close_out;
      end
   endtask
   // one-cycle instruction strobe: 0 wait, 1 stop
   task pulse(input int which);
      @(posedge clk);
      if (which == 0) wait_exec <= 1;
      else stop_exec <= 1;
      @(posedge clk);
      wait_exec <= 0;
      stop_exec <= 0;
      @(negedge clk);
   endtask
   // bounded wait for the core clock to return
   task clk_back(input int lim);
      n = 0;
      while (core_clk_en !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         fails++;
         close_out;
      end
   endtask
   task t_reset;
      chk("mask", core_mask, 1);
      bus(0, `LPM_OFF_OPT, 0);
      chk("opt", rd, 32'hA);
      bus(0, `LPM_OFF_WDOG, 0);
      chk("wdog", rd, 32'h0);
      bus(0, 4'hF, 0);
      chk("unmapped", rd, 0);
      bus(1, `LPM_OFF_CTRL, 0);
   endtask
   task t_wait;
      @(posedge clk);
      tbm_access <= 1;
      pulse(0);
      chk("in_wait", tim_mode.in_wait, 1);
      chk("mask", core_mask, 0);
      chk("tbm", tbm_access_ok, 0);
      chk("brk", brk_mode.in_wait, 1);
      chk("sysclk", system_clock_out_en, 1);
      @(posedge clk);
      wake_src.ext_irq <= 1;
      clk_back(50);
      chk("mask", core_mask, 0);
      @(posedge clk);
      wake_src <= '0;
      tbm_access <= 0;
   endtask
   // stop from the pll source with short recovery, keypad wake
   task t_stop_short;
      bus(1, `LPM_OFF_OPT, 32'hE);
      bus(1, `LPM_OFF_PLL, 32'h3);
      @(negedge clk);
      chk("pllsel", pll_select, 1);
      pulse(1);
      chk("in_stop", tim_mode.in_stop, 1);
      chk("mask", core_mask, 0);
      chk("xtal", crystal_clock_en, 0);
      chk("cgint", clockgen_interrupt_en, 0);
      chk("tbmstop", tbm_mode.in_stop, 1);
      @(posedge clk);
      wake_src.key_irq <= 1;
      clk_back(100);
      chk("short", n >= 32 && n <= 36, 1);
      @(posedge clk);
      wake_src <= '0;
      bus(0, `LPM_OFF_PLL, 0);
      chk("css", rd[`LPM_PLL_CSS], 0);
   endtask
   task t_stop_off;
      bus(1, `LPM_OFF_OPT, 32'h8);
      pulse(1);
      chk("refused", tim_mode.in_stop, 0);
      chk("run", core_clk_en, 1);
   endtask
   // oscillator kept in stop, full recovery
   task t_stop_osc;
      bus(1, `LPM_OFF_OPT, 32'hB);
      pulse(1);
      chk("xtal", crystal_clock_en, 1);
      chk("pll", pll_run, 0);
      chk("tbmrun", tbm_mode.in_stop, 0);
      @(posedge clk);
      wake_src.ext_irq <= 1;
      clk_back(5000);
      chk("long", n >= 4096 && n <= 4100, 1);
      @(posedge clk);
      wake_src <= '0;
   endtask
   task t_lvi;
      bus(1, `LPM_OFF_OPT, 32'h3A);
      pulse(0);
      @(posedge clk);
      lvi_low <= 1;
      n = 0;
      while (lvi_reset !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk("lvi", lvi_reset, 1);
      @(posedge clk);
      lvi_low <= 0;
      clk_back(200);
      chk("mask", core_mask, 1);
      // voltage monitor reset out of stop aborts sync serial
      bus(1, `LPM_OFF_OPT, 32'h3E);
      pulse(1);
      @(posedge clk);
      lvi_low <= 1;
      @(posedge clk);
      lvi_low <= 0;
      n = 0;
      while (spi_abort !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("abort", spi_abort, 1);
      clk_back(10);
      chk("mask", core_mask, 1);
   endtask
   // short limit so the watchdog times out inside wait
   task t_wdog;
      bus(1, `LPM_OFF_WDOG, 32'h4);
      pulse(0);
      n = 0;
      while (wd_reset !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk("wd", wd_reset, 1);
      chk("sysrst", sys_reset_req, 1);
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      t_reset;
      t_wait;
      t_stop_short;
      t_stop_off;
      t_stop_osc;
      t_lvi;
      t_wdog;
      close_out;
   end
   // hang guard
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      close_out;
   end
endmodule
`default_nettype wire

// ===== rtl/lpm_ctrl.sv
// low power mode controller with avalon register slave
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`include "lpm_map.svh"
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// register map overview
// ==========================================================
// word 0, control:
//    bit 0 masks external interrupt wake
//    bit 1 masks keypad interrupt wake
//    bit 2 lets break requests act in wait
// word 1, pll control:
//    bit 0 picks pll as system clock source
//    bit 1 powers the pll
// word 2, options:
//    bit 0 keeps the crystal running in stop
//    bit 1 allows the stop instruction
//    bit 2 short recovery after stop
//    bit 3 watchdog enable
//    bit 4 voltage monitor enable
//    bit 5 voltage monitor may reset
// word 3, status, read only:
//    bits 11:0 recovery count
//    bit 17 core interrupt mask
//    bit 18 in wait, bit 19 in stop
//    bit 20 break in standby flag
// word 4, command, write only:
//    bit 0 wait, bit 1 stop
//    bit 2 watchdog service, bit 3 break flag clear
// word 5, watchdog:
//    write sets the timeout limit, read gives the count
//
// hazards and limits:
//    every access costs one wait state, so read data
//    always comes from a flop, never from the mux
//    stop clears the clock source bit and software must
//    set it again after recovery; this is intended
//    recovery is counted in system clocks standing in
//    for crystal cycles, so a slower crystal stretches it
//    a voltage monitor reset during stop runs the recovery
//    count only if lvi_low drops the cycle after stop exit;
//    still high in recovery, the core restarts at once

// ==========================================================
// low power mode controller
// ==========================================================
// Operation
// - wait clears core mask, halts core clock
// - stop clears core mask, halts core clock
// - core clock waits stabilization delay after stop, 4096 or 32 cycles
// - break runs in wait, frozen in stop
// - break status flag readable, set by enabled break in wait
// - clock generator runs in wait; software controls
// - default stop kills oscillator, pll, outputs low
// - stop on pll source clears source select
// - osc-in-stop keeps crystal, kills pll
// - watchdog counts in wait, resets on timeout
// - stop gates watchdog and clears prescaler
// - stop enable option gates stop instruction
// - external irq unmasked wakes both modes
// - keypad irq unmasked wakes both modes
// - voltage monitor resets out of either mode
// - async serial runs, wakes from wait
// - async serial halts in stop, keeps state
// - sync serial runs, wakes from wait
// - sync serial halts in stop, reset aborts
// - timers run in wait, freeze in stop
// - timebase runs in wait, register blocked
// - timebase runs in stop with oscillator
// - recovery counter 4096 or 32 crystal cycles
module lpm_ctrl
   import lpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [`LPM_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // core instruction strobes
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic core_mask_set,
   // wake and reset sources
   input wire lpm_wake_t wake_src,
   input wire logic lvi_low,
   input wire logic tbm_access,
   // clock and mode outputs
   output logic core_mask,
   output logic core_clk_en,
   output logic crystal_clock_en,
   output logic system_clock_out_en,
   output logic clockgen_interrupt_en,
   output logic pll_run,
   output logic pll_select,
   output logic wd_reset,
   output logic lvi_reset,
   output logic sys_reset_req,
   output logic tbm_access_ok,
   output lpm_mode_t brk_mode,
   output lpm_mode_t sci_mode,
   output lpm_mode_t spi_mode,
   output lpm_mode_t tim_mode,
   output lpm_mode_t tbm_mode,
   output logic spi_abort
);

   lpm_state_t state_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] pll_control_reg;
   logic [7:0] option_register;
   logic break_in_standby_flag;
   logic [11:0] rec_cnt_reg;
   logic [7:0] wd_pre_reg;
   logic [15:0] wd_cnt_reg;
   logic [15:0] wd_limit_reg;
   logic stop_by_reset_reg;
   logic acc_done_reg;

   logic ext_irq_mask;
   logic keypad_irq_mask;
   logic osc_run_in_stop;
   logic short_recovery_select;
   logic wake_any;
   logic wake_stop;
   logic in_wait;
   logic in_stop;
   logic bus_req;
   logic wr_cmd;
   logic stop_go;
   logic wd_tick;

   assign ext_irq_mask = ctrl_reg[`LPM_CTRL_EXTMSK];
   assign keypad_irq_mask = ctrl_reg[`LPM_CTRL_KEYMSK];
   assign osc_run_in_stop = option_register[`LPM_OPT_OSCSTOP];
   assign short_recovery_select = option_register[`LPM_OPT_SHORT_RECOVERY_SELECT];
   assign in_wait = (state_reg == LPM_WAIT);
   assign in_stop = (state_reg == LPM_STOP) || (state_reg == LPM_RECOVER);

   // ======================================================
   // bus slave
   // ======================================================
   // one wait state per access keeps read data registered
   assign bus_req = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~acc_done_reg;
   assign wr_cmd = avs_write & acc_done_reg &
      (avs_address == `LPM_OFF_CMD);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_done_reg <= 1'b0;
      end else begin
         acc_done_reg <= bus_req & ~acc_done_reg;
      end
   end

   // read mux, unmapped addresses read zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~acc_done_reg) begin
         case (avs_address)
            `LPM_OFF_CTRL: avs_readdata <= {24'h00_0000, ctrl_reg};
            `LPM_OFF_PLL: avs_readdata <= {24'h00_0000, pll_control_reg};
            `LPM_OFF_OPT: avs_readdata <= {24'h00_0000, option_register};
            `LPM_OFF_STAT: avs_readdata <= {20'h0_0000, rec_cnt_reg}
               | {27'h000_0000, break_in_standby_flag, in_stop,
                  in_wait, core_mask, 1'b0} << 16;
            `LPM_OFF_WDOG: avs_readdata <= {16'h0000, wd_cnt_reg};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // control register: masks and break enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= 8'h00;
      end else if (avs_write & acc_done_reg &&
                   avs_address == `LPM_OFF_CTRL) begin
         ctrl_reg <= avs_writedata[7:0];
      end
   end

   // option register, write once style kept simple
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         option_register <= `LPM_OPT_RST;
      end else if (avs_write & acc_done_reg &&
                   avs_address == `LPM_OFF_OPT) begin
         option_register <= avs_writedata[7:0];
      end
   end

   // pll control; stop forces crystal source and it stays so
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pll_control_reg <= 8'h00;
      end else if (stop_go) begin
         pll_control_reg[`LPM_PLL_CSS] <= 1'b0;
      end else if (avs_write & acc_done_reg &&
                   avs_address == `LPM_OFF_PLL) begin
         pll_control_reg <= avs_writedata[7:0];
      end
   end

   // ======================================================
   // mode sequencer
   // ======================================================
   assign stop_go = (state_reg == LPM_RUN) &&
      (stop_exec || (wr_cmd && avs_writedata[`LPM_CMD_STOP])) &&
      option_register[`LPM_OPT_STOPEN];

   // unmasked external and keypad wake both modes
   assign wake_stop = (wake_src.ext_irq & ~ext_irq_mask) |
      (wake_src.key_irq & ~keypad_irq_mask) |
      (wake_src.tbm_irq & osc_run_in_stop);
   assign wake_any = wake_stop | wake_src.sci_irq |
      wake_src.spi_irq | wake_src.tim_irq |
      wake_src.tbm_irq | wake_src.cgm_irq |
      (wake_src.brk_irq & ctrl_reg[`LPM_CTRL_BRKEN]);

   assign lvi_reset = option_register[`LPM_OPT_LVIEN] &
      option_register[`LPM_OPT_LVIRST] & lvi_low;
   assign sys_reset_req = lvi_reset | wd_reset;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= LPM_RUN;
      end else if (sys_reset_req && state_reg != LPM_STOP) begin
         state_reg <= LPM_RUN;
      end else begin
         case (state_reg)
            LPM_RUN: begin
               if (stop_go) begin
                  state_reg <= LPM_STOP;
               end else if (wait_exec ||
                  (wr_cmd && avs_writedata[`LPM_CMD_WAIT])) begin
                  state_reg <= LPM_WAIT;
               end
            end
            LPM_WAIT: begin
               if (wake_any) begin
                  state_reg <= LPM_RUN;
               end
            end
            LPM_STOP: begin
               if (wake_stop || lvi_reset) begin
                  state_reg <= LPM_RECOVER;
               end
            end
            LPM_RECOVER: begin
               if (rec_cnt_reg == 12'h000) begin
                  state_reg <= LPM_RUN;
               end
            end
            default: state_reg <= LPM_RUN;
         endcase
      end
   end

   // recovery counter loaded on stop exit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rec_cnt_reg <= 12'h000;
      end else if (state_reg == LPM_STOP) begin
         rec_cnt_reg <= short_recovery_select ?
            `LPM_REC_SHORT : `LPM_REC_LONG;
      end else if (state_reg == LPM_RECOVER && rec_cnt_reg != 12'h000) begin
         rec_cnt_reg <= rec_cnt_reg - 12'h001;
      end
   end

   // remember whether stop was left by reset, for serial abort
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stop_by_reset_reg <= 1'b0;
      end else if (state_reg == LPM_STOP) begin
         stop_by_reset_reg <= lvi_reset;
      end else if (state_reg == LPM_RUN) begin
         stop_by_reset_reg <= 1'b0;
      end
   end
   assign spi_abort = stop_by_reset_reg &&
      state_reg == LPM_RECOVER && rec_cnt_reg == 12'h000;

   // core mask: cleared on entry, set again by reset exit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_mask <= 1'b1;
      end else if (sys_reset_req || core_mask_set) begin
         core_mask <= 1'b1;
      end else if (state_reg == LPM_RUN && (stop_go || wait_exec ||
                   (wr_cmd && avs_writedata[`LPM_CMD_WAIT]))) begin
         core_mask <= 1'b0;
      end
   end

   // break flag set by an enabled break request in wait, held through stop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         break_in_standby_flag <= 1'b0;
      end else if (in_wait && wake_src.brk_irq &&
                   ctrl_reg[`LPM_CTRL_BRKEN]) begin
         break_in_standby_flag <= 1'b1;
      end else if (wr_cmd && avs_writedata[`LPM_CMD_BRKCLR] && !in_stop) begin
         break_in_standby_flag <= 1'b0;
      end
   end

   // ======================================================
   // clock gating
   // ======================================================
   always_comb begin
      core_clk_en = (state_reg == LPM_RUN);
      crystal_clock_en = !(in_stop && !osc_run_in_stop);
      system_clock_out_en = !in_stop;
      clockgen_interrupt_en = !in_stop;
      pll_run = pll_control_reg[`LPM_PLL_PON] && !in_stop;
      pll_select = pll_control_reg[`LPM_PLL_CSS];
      tbm_access_ok = tbm_access && !in_wait && !in_stop;
   end

   // per peripheral mode indications
   always_comb begin
      brk_mode = '{in_wait: in_wait, in_stop: in_stop};
      sci_mode = '{in_wait: in_wait, in_stop: in_stop};
      spi_mode = '{in_wait: in_wait, in_stop: in_stop};
      tim_mode = '{in_wait: in_wait, in_stop: in_stop};
      tbm_mode = '{in_wait: in_wait,
                   in_stop: in_stop && !osc_run_in_stop};
   end

   // ======================================================
   // watchdog
   // ======================================================
   // prescaler runs off crystal clock; stop clears it
   assign wd_tick = (wd_pre_reg == `LPM_WD_PRE_MAX);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_pre_reg <= 8'h00;
      end else if (in_stop ||
                   (wr_cmd && avs_writedata[`LPM_CMD_WDSVC])) begin
         wd_pre_reg <= 8'h00;
      end else begin
         wd_pre_reg <= wd_pre_reg + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_limit_reg <= `LPM_WD_RST;
      end else if (avs_write & acc_done_reg &&
                   avs_address == `LPM_OFF_WDOG) begin
         wd_limit_reg <= avs_writedata[15:0];
      end
   end

   // counter frozen in stop; service restarts full period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_cnt_reg <= 16'h0000;
      end else if (wr_cmd && avs_writedata[`LPM_CMD_WDSVC]) begin
         wd_cnt_reg <= 16'h0000;
      end else if (wd_tick && !in_stop &&
                   option_register[`LPM_OPT_WDEN]) begin
         wd_cnt_reg <= wd_cnt_reg + 16'h0001;
      end
   end

   assign wd_reset = option_register[`LPM_OPT_WDEN] &&
      (wd_cnt_reg >= wd_limit_reg);

endmodule
`default_nettype wire

// ===== rtl/lpm_map.svh
// register offsets, field positions, reset values and counts for lpm
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_ADDR_W 4
`define LPM_OFF_CTRL 4'h0
`define LPM_OFF_PLL 4'h1
`define LPM_OFF_OPT 4'h2
`define LPM_OFF_STAT 4'h3
`define LPM_OFF_CMD 4'h4
`define LPM_OFF_WDOG 4'h5
// pll control fields
`define LPM_PLL_CSS 0
`define LPM_PLL_PON 1
// option fields
`define LPM_OPT_OSCSTOP 0
`define LPM_OPT_STOPEN 1
`define LPM_OPT_SHORT_RECOVERY_SELECT 2
`define LPM_OPT_WDEN 3
`define LPM_OPT_LVIEN 4
`define LPM_OPT_LVIRST 5
`define LPM_OPT_RST 8'h0A
// control fields
`define LPM_CTRL_EXTMSK 0
`define LPM_CTRL_KEYMSK 1
`define LPM_CTRL_BRKEN 2
// command bits
`define LPM_CMD_WAIT 0
`define LPM_CMD_STOP 1
`define LPM_CMD_WDSVC 2
`define LPM_CMD_BRKCLR 3
// recovery counts in crystal cycles
`define LPM_REC_LONG 12'hFFF
`define LPM_REC_SHORT 12'h01F
`define LPM_WD_PRE_MAX 8'hFF
`define LPM_WD_RST 16'hFFFF
`endif

// ===== rtl/lpm_pkg.sv
// types shared by the low power mode controller
package lpm_pkg;
   typedef enum logic [1:0] {
      LPM_RUN,
      LPM_WAIT,
      LPM_STOP,
      LPM_RECOVER
   } lpm_state_t;

   // per peripheral mode indications
   typedef struct packed {
      logic in_wait;
      logic in_stop;
   } lpm_mode_t;

   // wake sources sampled by the controller
   typedef struct packed {
      logic ext_irq;
      logic key_irq;
      logic sci_irq;
      logic spi_irq;
      logic tim_irq;
      logic tbm_irq;
      logic brk_irq;
      logic cgm_irq;
   } lpm_wake_t;
endpackage
